// File: shared/rco_map.svh
// register offsets, reset values and field positions of the reference clock output
`ifndef RCO_MAP_SVH
`define RCO_MAP_SVH

// byte addresses of the two registers on the apb window
`define RCO_CTRL_OFS     12'h000
`define RCO_SRC_OFS      12'h004

// reset values: duty msb loads as one, giving 50 percent
`define RCO_CTRL_RST     8'h10
`define RCO_SRC_RST      8'h00

// writable bits; everything else reads as zero
`define RCO_CTRL_WMASK   8'h9F
`define RCO_SRC_WMASK    8'h0F

// field positions inside the control register
`define RCO_EN_BIT       7
`define RCO_DUTY_HI      4
`define RCO_DUTY_LO      3
`define RCO_DIV_HI       2
`define RCO_DIV_LO       0

// highest defined source code, codes above it are reserved
`define RCO_SRC_LAST     4'hA

// divider arithmetic: one period is two half-cycles per divided source period
`define RCO_ONE_NPER     9'h001
`define RCO_PHASE_ZERO   8'h00
`define RCO_PHASE_STEP   8'h01
`define RCO_DIV_NONE     3'h0

`endif

// File: shared/rco_pkg.sv
// types shared by the reference clock output design
`default_nettype none

package rco_pkg;

    // control register layout
    typedef struct packed {
        logic       enable;
        logic [1:0] rsvd;
        logic [1:0] duty_sel;
        logic [2:0] divider_sel;
    } rco_ctrl_t;

    // candidate source clock levels, one bit per selectable input
    typedef struct packed {
        logic logic_cell_four_output;
        logic logic_cell_three_output;
        logic logic_cell_two_output;
        logic logic_cell_one_output;
        logic numeric_osc_one;
        logic secondary_osc;
        logic medium_freq_internal_osc_slow;
        logic medium_freq_internal_osc;
        logic low_freq_internal_osc;
        logic high_freq_internal_osc;
        logic system_osc;
    } rco_src_t;

    // apb request from the master
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } rco_apb_req_t;

    // generator sequencing
    typedef enum logic [1:0] {
        RCO_IDLE,
        RCO_ARM,
        RCO_RUN
    } rco_state_t;

endpackage : rco_pkg

`default_nettype wire

// File: core/rco_divider.sv
// phase counter and duty-cycle waveform of the reference clock output
`default_nettype none

module rco_divider (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // sequencing from the top
    input  wire logic       run,
    input  wire logic       start,
    input  wire logic       hold,
    input  wire logic       src_edge,
    input  wire logic       src_lvl,
    // settings
    input  wire logic [2:0] divider_sel,
    input  wire logic [1:0] duty_sel,
    // results
    output logic      [7:0] phase,
    output logic            wave
);
    import rco_pkg::*;
    `include "rco_map.svh"

    logic [7:0] phase_q;
    logic [7:0] phase_d;
    logic       wave_q;
    logic       wave_d;
    logic [8:0] nper;
    logic [9:0] thr;
    logic [7:0] last;

    // source periods per output period, last phase and the high-time threshold
    assign nper = `RCO_ONE_NPER << divider_sel;
    assign last = 8'(({nper, 1'b0}) - 10'h001);
    assign thr  = 10'((nper * duty_sel) >> 1);

    // next phase and waveform; counters stay cleared unless running
    always_comb begin
        phase_d = phase_q;
        wave_d  = wave_q;
        if (start) begin
            phase_d = `RCO_PHASE_ZERO;
            wave_d  = (divider_sel == `RCO_DIV_NONE) ? 1'b1 : (thr != 10'h000);
        end else if (!run) begin
            phase_d = `RCO_PHASE_ZERO;
            wave_d  = 1'b0;
        end else if (hold) begin
            phase_d = phase_q;
            wave_d  = wave_q;
        end else if (divider_sel == `RCO_DIV_NONE) begin
            wave_d  = src_lvl;
        end else if (src_edge) begin
            phase_d = (phase_q == last) ? `RCO_PHASE_ZERO
                                        : phase_q + `RCO_PHASE_STEP;
            wave_d  = ({2'b00, phase_d} < thr);
        end
    end

    // state only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= `RCO_PHASE_ZERO;
            wave_q  <= 1'b0;
        end else begin
            phase_q <= phase_d;
            wave_q  <= wave_d;
        end
    end

    assign phase = phase_q;
    assign wave  = wave_q;

endmodule : rco_divider

`default_nettype wire

// File: core/rco_top.sv
// reference clock output: apb registers, source select and output sequencing
//
// Notes on behaviour
// - output is selected source divided per divider
// - divider code 000 undivided, 111 divides 128
// - start after enable is glitch-free
// - clearing enable stops output at once
// - divider and duty accepted while running
// - duty selects 0, 25, 50 or 75 percent
// - undivided output follows source, duty ignored
// - duty msb resets to one
// - sleep freezes output at present level
// - source select in bits 3-0, rest zero
// - source codes map oscillators, logic cells, reserved
`default_nettype none

module rco_top (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire rco_pkg::rco_apb_req_t apb_req,
    output logic               [31:0] prdata,
    output logic                      pready,
    output logic                      pslverr,
    // candidate source clocks and power state
    input  wire rco_pkg::rco_src_t     src_in,
    input  wire logic                 sleep,
    // reference clock pin
    output logic                      refclk_out_pin
);
    import rco_pkg::*;
    `include "rco_map.svh"

    // registers
    rco_ctrl_t  ctrl_q;
    rco_ctrl_t  ctrl_d;
    logic [3:0] src_code_q;
    logic [3:0] src_code_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;

    // generator state
    rco_state_t  st_q;
    rco_state_t  st_d;
    logic        src_q;
    logic        src_d;
    logic        src_prev_q;
    logic        src_rise;
    logic        src_edge;
    logic        start;
    logic [7:0]  phase;
    logic        wave;

    // bus decode
    logic        access;
    logic        hit_ctrl;
    logic        hit_src;
    logic        commit;

    assign access   = apb_req.psel & apb_req.penable;
    assign hit_ctrl = (apb_req.paddr == `RCO_CTRL_OFS);
    assign hit_src  = (apb_req.paddr == `RCO_SRC_OFS);
    // a write takes effect only at the edge that also sees pready high
    assign commit   = access & pready_q & apb_req.pwrite;

    // register writes; no lockout while running, so software owns glitches
    always_comb begin
        ctrl_d     = ctrl_q;
        src_code_d = src_code_q;
        if (commit && hit_ctrl) begin
            ctrl_d = rco_ctrl_t'(apb_req.pwdata[7:0] & `RCO_CTRL_WMASK);
        end
        if (commit && hit_src) begin
            src_code_d = apb_req.pwdata[3:0];
        end
    end

    // apb answer: one wait state, then pready with data or error
    always_comb begin
        pready_d  = access & ~pready_q;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (pready_d) begin
            pslverr_d = ~(hit_ctrl | hit_src);
            if (!apb_req.pwrite && hit_ctrl) begin
                prdata_d = {24'h00_0000, 8'(ctrl_q)};
            end else if (!apb_req.pwrite && hit_src) begin
                prdata_d = {28'h000_0000, src_code_q};
            end
        end
    end

    // register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= rco_ctrl_t'(`RCO_CTRL_RST);
            src_code_q <= 4'(`RCO_SRC_RST);
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            src_code_q <= src_code_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
        end
    end

    // source select; reserved codes give a quiet low source
    always_comb begin
        src_d = 1'b0;
        unique case (src_code_q)
            4'h0:    src_d = src_in.system_osc;
            4'h1:    src_d = src_in.high_freq_internal_osc;
            4'h2:    src_d = src_in.low_freq_internal_osc;
            4'h3:    src_d = src_in.medium_freq_internal_osc;
            4'h4:    src_d = src_in.medium_freq_internal_osc_slow;
            4'h5:    src_d = src_in.secondary_osc;
            4'h6:    src_d = src_in.numeric_osc_one;
            4'h7:    src_d = src_in.logic_cell_one_output;
            4'h8:    src_d = src_in.logic_cell_two_output;
            4'h9:    src_d = src_in.logic_cell_three_output;
            4'hA:    src_d = src_in.logic_cell_four_output;
            default: src_d = 1'b0;
        endcase
        if (sleep) begin
            src_d = src_q;
        end
    end

    // edges of the sampled source; the source sits in the pclk domain
    assign src_rise = src_q & ~src_prev_q;
    assign src_edge = src_q ^ src_prev_q;
    // first cycle only at a source rise, so no runt pulse can appear
    assign start    = (st_q == RCO_ARM) & src_rise & ~sleep;

    // sequencing: disable wins over everything, even sleep
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            RCO_IDLE: if (ctrl_q.enable) st_d = RCO_ARM;
            RCO_ARM:  if (start) st_d = RCO_RUN;
            RCO_RUN:  st_d = RCO_RUN;
        endcase
        if (!ctrl_q.enable) begin
            st_d = RCO_IDLE;
        end
    end

    // generator state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= RCO_IDLE;
            src_q      <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            src_q      <= src_d;
            src_prev_q <= src_q;
        end
    end

    // waveform generator; run drops the same cycle that enable clears
    rco_divider u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         ((st_q == RCO_RUN) & ctrl_q.enable),
        .start       (start & ctrl_q.enable),
        .hold        (sleep),
        .src_edge    (src_edge),
        .src_lvl     (src_q),
        .divider_sel (ctrl_q.divider_sel),
        .duty_sel    (ctrl_q.duty_sel),
        .phase       (phase),
        .wave        (wave)
    );

    // outputs, all from flops
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign refclk_out_pin = wave;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access_wait;
        apb_req.psel && apb_req.penable && !pready_q;
    endsequence

    sequence s_armed_no_rise;
        (st_q == RCO_ARM) && !src_rise;
    endsequence

    a_apb_ready_time: assert property (s_access_wait |=> pready_q)
        else $error("apb access not answered after one wait state");

    a_ctrl_rsvd_zero: assert property (ctrl_q.rsvd == 2'b00)
        else $error("control bits 6-5 not zero");

    a_src_rsvd_zero: assert property (
        (pready_d && !apb_req.pwrite && hit_src) |=> (prdata_q[31:4] == 28'h000_0000))
        else $error("source select upper bits not zero");

    a_reserved_src_low: assert property (
        (src_code_q > `RCO_SRC_LAST && !sleep) |=> !src_q)
        else $error("reserved source code not quiet");

    a_disable_low: assert property (!ctrl_q.enable |=> !refclk_out_pin ##1 !refclk_out_pin)
        else $error("output not low after disable");

    a_disable_clear: assert property (!ctrl_q.enable |=> (phase == `RCO_PHASE_ZERO))
        else $error("phase not cleared while disabled");

    a_start_clean: assert property (
        (s_armed_no_rise ##0 ctrl_q.enable) |=> !refclk_out_pin)
        else $error("output moved before first source rise");

    a_start_run: assert property (
        (start && ctrl_q.enable) |=> (st_q == RCO_RUN) && (phase == `RCO_PHASE_ZERO))
        else $error("start did not enter run at phase zero");

    a_undiv_follow: assert property (
        (st_q == RCO_RUN && ctrl_q.enable && !sleep && ctrl_q.divider_sel == `RCO_DIV_NONE)
        |=> refclk_out_pin == $past(src_q))
        else $error("undivided output does not follow source");

    a_phase_wrap: assert property (
        (st_q == RCO_RUN && ctrl_q.enable && !sleep && src_edge
         && ctrl_q.divider_sel == 3'h7 && phase == 8'hFF)
        |=> phase == `RCO_PHASE_ZERO)
        else $error("divide by 128 did not wrap after 256 half-cycles");

    a_half_duty: assert property (
        (st_q == RCO_RUN && ctrl_q.enable && !sleep && src_edge
         && ctrl_q.divider_sel == 3'h1 && ctrl_q.duty_sel == 2'h2 && phase == 8'h01)
        |=> !refclk_out_pin)
        else $error("50 percent at divide by 2 wrong");

    a_sleep_hold: assert property (
        (sleep && ctrl_q.enable && st_q == RCO_RUN) [*2] |-> $stable(refclk_out_pin))
        else $error("output changed during sleep");

    // register landing and decode; a stray address must never touch state
    sequence s_ctrl_write;
        commit && hit_ctrl;
    endsequence

    sequence s_src_write;
        commit && hit_src;
    endsequence

    sequence s_unmapped_wait;
        access && !pready_q && !hit_ctrl && !hit_src;
    endsequence

    // generator running and awake
    sequence s_live_run;
        (st_q == RCO_RUN) && ctrl_q.enable && !sleep;
    endsequence

    a_ctrl_write: assert property (
        s_ctrl_write
        |=> 8'(ctrl_q) == ($past(apb_req.pwdata[7:0]) & `RCO_CTRL_WMASK))
        else $error("control write did not land");

    a_src_write: assert property (
        s_src_write |=> src_code_q == $past(apb_req.pwdata[3:0]))
        else $error("source select write did not land");

    a_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("pready stood longer than one cycle");

    a_unmapped_err: assert property (
        s_unmapped_wait |=> pready_q && pslverr_q)
        else $error("unmapped access not flagged");

    a_unmapped_keep: assert property (
        (commit && !hit_ctrl && !hit_src) |=> $stable(ctrl_q) && $stable(src_code_q))
        else $error("unmapped write changed a register");

    a_arm_next: assert property (
        (st_q == RCO_IDLE && ctrl_q.enable) |=> st_q == RCO_ARM)
        else $error("enable did not arm the generator");

    a_start_level: assert property (
        (start && ctrl_q.enable
         && (ctrl_q.divider_sel == `RCO_DIV_NONE || ctrl_q.duty_sel != 2'h0))
        |=> refclk_out_pin)
        else $error("first output pulse missing at start");

    a_zero_duty_start: assert property (
        (start && ctrl_q.enable && ctrl_q.divider_sel != `RCO_DIV_NONE
         && ctrl_q.duty_sel == 2'h0) |=> !refclk_out_pin)
        else $error("zero duty produced a pulse at start");

    a_src_system: assert property (
        (src_code_q == 4'h0 && !sleep)
        |=> src_q == $past(src_in.system_osc))
        else $error("system oscillator not picked for code zero");

    a_src_cell_four: assert property (
        (src_code_q == `RCO_SRC_LAST && !sleep)
        |=> src_q == $past(src_in.logic_cell_four_output))
        else $error("fourth logic cell not picked for its code");

    a_sleep_src_hold: assert property (sleep |=> $stable(src_q))
        else $error("source sampling moved during sleep");

    a_sleep_phase: assert property (
        (sleep && ctrl_q.enable && st_q == RCO_RUN) |=> $stable(phase))
        else $error("phase moved during sleep");

    // phase may only move on a source edge, else the ratio drifts
    a_phase_idle: assert property (
        (s_live_run ##0 (!src_edge && ctrl_q.divider_sel != `RCO_DIV_NONE))
        |=> $stable(phase))
        else $error("phase moved without a source edge");

    a_phase_step: assert property (
        (s_live_run ##0 (src_edge && ctrl_q.divider_sel == 3'h1
                          && phase == `RCO_PHASE_ZERO))
        |=> phase == `RCO_PHASE_STEP)
        else $error("phase did not advance on a source edge");

endmodule : rco_top

`default_nettype wire

// File: bench/rco_src_model.sv
// free-running source clock levels feeding the reference clock output
`default_nettype none

module rco_src_model (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // source levels, bit i toggles every i+2 cycles
    output var rco_pkg::rco_src_t  src_out
);
    import rco_pkg::*;

    logic [3:0] cnt_q [11];

    // oscillators run free; distinct rates expose a wrong source pick
    always_ff @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < 11; i++) begin
            if (!presetn) begin
                cnt_q[i]   <= 4'h0;
                src_out[i] <= 1'b0;
            end else if (cnt_q[i] == 4'(i + 1)) begin
                cnt_q[i]   <= 4'h0;
                src_out[i] <= ~src_out[i];
            end else begin
                cnt_q[i] <= cnt_q[i] + 4'h1;
            end
        end
    end
endmodule : rco_src_model

`default_nettype wire

// File: bench/reference_clock_output_tb.sv
// self-checking bench for the reference clock output
`default_nettype none
`include "rco_map.svh"

module reference_clock_output_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rco_pkg::*;

    localparam logic [11:0] CTRL_A = `RCO_CTRL_OFS;
    localparam logic [11:0] SRC_A  = `RCO_SRC_OFS;

    logic         pclk;
    logic         presetn;
    rco_apb_req_t apb_req;
    logic  [31:0] prdata;
    logic         pready;
    logic         pslverr;
    rco_src_t     src_in;
    logic         sleep;
    logic         refclk_out_pin;
    int           fail_count;
    int           cmp_count;
    logic  [31:0] rd;
    logic         err;

    rco_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_in(src_in), .sleep(sleep),
        .refclk_out_pin(refclk_out_pin));
    rco_src_model u_src (.pclk(pclk), .presetn(presetn), .src_out(src_in));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic hang(input string what);
        fail_count++;
        $display("wrong value %s expected event seen timeout", what);
        summarize();
    endtask : hang

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) hang("pready");
        rd  = prdata;
        err = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // settings land while disabled, then enable alone
    task automatic cfg(input logic [7:0] v);
        apb(1'b1, CTRL_A, {24'h0, v & 8'h7F});
        apb(1'b1, CTRL_A, {24'h0, v});
    endtask : cfg

    task automatic step();
        @(posedge pclk);
        #1;
    endtask : step

    task automatic low(input string what, input int n);
        repeat (n) begin
            step();
            chk(what, refclk_out_pin, 1'b0);
        end
    endtask : low

    // length of the next high and low phase, in pclk cycles
    task automatic meas(input string what, input bit sync, input int hi, input int lo);
        int n;
        int h;
        int l;
        for (n = 0; n < 3000 && sync && refclk_out_pin === 1'b1; n++) step();
        for (n = 0; n < 3000 && refclk_out_pin !== 1'b1; n++) step();
        if (n == 3000) hang(what);
        for (h = 0; h < 3000 && refclk_out_pin === 1'b1; h++) step();
        for (l = 0; l < 3000 && refclk_out_pin !== 1'b1; l++) step();
        chk(what, h, hi);
        chk(what, l, lo);
    endtask : meas

    task automatic t_regs();
        apb(1'b0, CTRL_A, 32'h0);
        chk("ctrl reset", rd, 32'h10);
        apb(1'b0, SRC_A, 32'h0);
        chk("src reset", rd, 32'h0);
        chk("pin reset", refclk_out_pin, 1'b0);
        apb(1'b1, CTRL_A, 32'hFFFF_FF7F);
        apb(1'b0, CTRL_A, 32'h0);
        chk("ctrl bits", rd, 32'h1F);
        apb(1'b1, SRC_A, 32'hFF);
        apb(1'b1, 12'h008, 32'h0);
        chk("unmapped err", err, 1'b1);
        apb(1'b0, SRC_A, 32'h0);
        chk("src bits", rd, 32'h0F);
        chk("mapped err", err, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped data", rd, 32'h0);
        chk("unmapped read err", err, 1'b1);
        $display("test registers done");
    endtask : t_regs

    task automatic t_div();
        apb(1'b1, SRC_A, 32'h0);
        for (int d = 0; d < 8; d++) begin
            cfg(8'h90 | 8'(d));
            meas("divider", 0, 2 << d, 2 << d);
        end
        $display("test dividers done");
    endtask : t_div

    task automatic t_duty();
        for (int c = 1; c < 4; c++) begin
            cfg(8'h82 | 8'(c << 3));
            meas("duty", 0, 4 * c, 16 - 4 * c);
        end
        cfg(8'h82);
        low("duty zero", 40);
        cfg(8'h88);
        meas("undivided", 0, 2, 2);
        $display("test duty done");
    endtask : t_duty

    task automatic t_src();
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, CTRL_A, 32'h10);
            apb(1'b1, SRC_A, 32'(i));
            cfg(8'h90);
            if (i < 11) meas("source", 0, i + 2, i + 2);
            else low("reserved source", 40);
        end
        apb(1'b1, SRC_A, 32'h0);
        $display("test sources done");
    endtask : t_src

    task automatic t_stop();
        int n;
        cfg(8'hDF);
        for (n = 0; n < 600 && refclk_out_pin !== 1'b1; n++) step();
        if (n == 600) hang("start");
        apb(1'b1, CTRL_A, 32'h5F);
        step();
        chk("stop", refclk_out_pin, 1'b0);
        low("stopped", 20);
        cfg(8'h92);
        meas("restart", 0, 8, 8);
        apb(1'b1, CTRL_A, 32'h92);
        meas("live", 1, 8, 8);
        $display("test stop done");
    endtask : t_stop

    task automatic t_sleep();
        logic lvl;
        cfg(8'h93);
        repeat (37) step();
        @(posedge pclk);
        sleep <= 1'b1;
        repeat (3) step();
        lvl = refclk_out_pin;
        repeat (100) begin
            step();
            chk("sleep hold", refclk_out_pin, lvl);
        end
        @(posedge pclk);
        sleep <= 1'b0;
        meas("wake", 1, 16, 16);
        $display("test sleep done");
    endtask : t_sleep

    // reset, then scenarios in turn
    initial begin
        fail_count = 0;
        cmp_count  = 0;
        presetn    = 1'b0;
        sleep      = 1'b0;
        apb_req    = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_div();
        t_duty();
        t_src();
        t_stop();
        t_sleep();
        summarize();
    end
endmodule : reference_clock_output_tb

`default_nettype wire
